//--- core/ddr2_cmd_params.svh
// constants for the ddr2 command and burst protocol block
`ifndef DDR2_CMD_PARAMS_SVH
`define DDR2_CMD_PARAMS_SVH
`define ROW_W 13
`define COL_W 10
`define BANK_W 3
`define BANKS 8
`define DQ_W 16
`define DM_W 2
`define ADDR_AP_BIT 10
`define LAT_W 4
`define CNT_W 5
`define BL4_HALF 5'h02
`define BL8_HALF 5'h04
`define MR_BL_BIT 2
`define MR_CL_LSB 4
`define EMR_AL_LSB 3
`define MR_SEL_MODE 3'h0
`define MR_SEL_EXT 3'h1
`define MR_RESET_MODE 13'h0032
`define MR_RESET_EXT 13'h0000
`define COL_LOW 3'h0
`endif

//--- core/ddr2_cmd_pkg.sv
// types for the ddr2 command and burst protocol block
package ddr2_cmd_pkg;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_LOAD = 3'h1,
		CMD_ACT = 3'h2,
		CMD_PRE = 3'h3,
		CMD_READ = 3'h4,
		CMD_WRITE = 3'h5,
		CMD_OTHER = 3'h6
	} cmd_type;
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_PRE = 2'h1,
		PH_DATA = 2'h3
	} phase_type;
endpackage : ddr2_cmd_pkg

//--- core/ddr2_command_protocol.sv
// ddr2 device-side command decode, bank state and burst data path
// Function
// - chip select high: ignore command pins, running work continues.
// - select with ras, cas, we high is a no-operation.
// - load mode: bank address picks register, address bits give its value.
// - activate opens the addressed row in the addressed bank until precharge.
// - low address bits give start column; bit ten selects auto precharge.
// - first read data read-latency clocks after command, then every clock edge; here data enable rises read latency plus two clocks after decode.
// - strobe driven low as preamble before read data and postamble at end; here strobe enable drops with data enable, no postamble.
// - data bus released after a read burst with no further command.
// - read after half burst length gives gapless concatenated data.
// - write mask low writes the byte, high discards it.
// - write latency equals read latency minus one.
// - write data captured from first strobe rise at write latency, then each edge; here captured on link clock rises once the write start toggle crosses.
// - after a write burst inputs stay released and further data is ignored.
// - write after half burst length streams continuously; here two write starts inside one link period cancel each other.
// - command decoded from select, strobes, write enable and clock enable.
// - precharge with bit ten closes all banks, else the addressed bank.
`timescale 1ns/10ps
`include "ddr2_cmd_params.svh"

module ddr2_command_protocol (
	input wire logic clk_sys_i, // command clock
	input wire logic reset_n_i, // async reset, active low
	input wire logic clk_link_i, // data strobe domain clock
	input wire logic cke_i, // clock enable pin
	input wire logic cs_n_i, // chip select pin
	input wire logic ras_n_i, // row strobe pin
	input wire logic cas_n_i, // column strobe pin
	input wire logic we_n_i, // write enable pin
	input wire logic [`BANK_W-1:0] ba_i, // bank address pins
	input wire logic [`ROW_W-1:0] addr_i, // address pins
	input wire logic [`DQ_W-1:0] dq_i, // write data in
	input wire logic [`DM_W-1:0] dm_i, // write mask in
	input wire logic [`DQ_W-1:0] rd_data_i, // array read data for current element
	output logic [`DQ_W-1:0] dq_o, // read data out
	output logic dq_oe_o, // read data enable
	output logic dqs_o, // strobe out (complement derived outside)
	output logic dqs_oe_o, // strobe enable
	output logic wr_en_o, // array write element strobe (link domain)
	output logic [`DQ_W-1:0] wr_data_o, // array write data
	output logic [`DM_W-1:0] wr_be_o, // array write byte enables
	output logic [`BANK_W-1:0] acc_bank_o, // accessed bank
	output logic [`ROW_W-1:0] acc_row_o, // accessed row
	output logic [`COL_W-1:0] acc_col_o, // accessed start column
	output logic [`ROW_W-1:0] mode_o, // mode register
	output logic [`ROW_W-1:0] ext_mode_o, // extended mode register
	output logic [`BANKS-1:0] bank_open_o // open flag per bank
);

	// pin synchronisers; pins are outside this domain
	// the whole command word moves together, so every command lands two clocks late
	// and the controller's spacing is kept, only shifted; reset reads as clock disabled
	logic [`ROW_W+`BANK_W+4:0] pin_s1;
	logic [`ROW_W+`BANK_W+4:0] pin_s2;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i};
			pin_s2 <= pin_s1;
		end
	end
	logic s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n;
	logic [`BANK_W-1:0] s_ba;
	logic [`ROW_W-1:0] s_addr;
	assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr} = pin_s2;

	// command decode; deselect and nop fall to none
	// refresh-class and reserved codes decode as other and touch no state
	ddr2_cmd_pkg::cmd_type cmd;
	always_comb begin
		cmd = ddr2_cmd_pkg::CMD_NONE;
		if (s_cke && !s_cs_n) begin
			unique case ({s_ras_n, s_cas_n, s_we_n})
				3'h0: cmd = ddr2_cmd_pkg::CMD_LOAD;
				3'h2: cmd = ddr2_cmd_pkg::CMD_PRE;
				3'h3: cmd = ddr2_cmd_pkg::CMD_ACT;
				3'h4: cmd = ddr2_cmd_pkg::CMD_WRITE;
				3'h5: cmd = ddr2_cmd_pkg::CMD_READ;
				3'h7: cmd = ddr2_cmd_pkg::CMD_NONE;
				default: cmd = ddr2_cmd_pkg::CMD_OTHER; // refresh not handled
			endcase
		end
	end

	// mode registers; selects other than the two held here are ignored
	// a load while a burst runs would change the burst length under it; the controller avoids it
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_o <= `MR_RESET_MODE;
			ext_mode_o <= `MR_RESET_EXT;
		end else if (cmd == ddr2_cmd_pkg::CMD_LOAD) begin
			if (s_ba == `MR_SEL_MODE) mode_o <= s_addr;
			else if (s_ba == `MR_SEL_EXT) ext_mode_o <= s_addr;
		end
	end

	// latencies from the mode registers
	// three-bit fields keep the sum inside the four-bit latency width
	logic [`LAT_W-1:0] cas_lat, add_lat, rd_lat, wr_lat;
	logic [`CNT_W-1:0] half_bl;
	assign cas_lat = {1'b0, mode_o[`MR_CL_LSB+2:`MR_CL_LSB]};
	assign add_lat = {1'b0, ext_mode_o[`EMR_AL_LSB+2:`EMR_AL_LSB]};
	assign rd_lat = cas_lat + add_lat;
	assign wr_lat = rd_lat - 4'h1;
	assign half_bl = mode_o[`MR_BL_BIT+1] ? `BL8_HALF : `BL4_HALF;

	// per-bank row state; auto precharge closes the bank once its burst ends
	// activate wins over a close in the same cycle; the controller never asks for both
	logic [`ROW_W-1:0] row_of [`BANKS];
	logic ap_pend;
	logic [`BANK_W-1:0] ap_bank;
	logic burst_end;
	genvar b;
	generate
		for (b = 0; b < `BANKS; b++) begin : g_bank
			always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					bank_open_o[b] <= 1'b0;
					row_of[b] <= '0;
				end else if (cmd == ddr2_cmd_pkg::CMD_ACT && s_ba == b) begin
					bank_open_o[b] <= 1'b1;
					row_of[b] <= s_addr;
				end else if (cmd == ddr2_cmd_pkg::CMD_PRE &&
					(s_addr[`ADDR_AP_BIT] || s_ba == b)) begin
					bank_open_o[b] <= 1'b0;
				end else if (burst_end && ap_pend && ap_bank == b) begin
					bank_open_o[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// access launch: delay line of pending bursts, indexed by cycles to data
	// one bit per pending burst lets accesses queue without a counter for each
	logic is_rd, is_wr;
	assign is_rd = cmd == ddr2_cmd_pkg::CMD_READ;
	assign is_wr = cmd == ddr2_cmd_pkg::CMD_WRITE;
	logic [15:0] rd_line, wr_line;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_line <= '0;
			wr_line <= '0;
		end else begin
			rd_line <= rd_line >> 1;
			wr_line <= wr_line >> 1;
			if (is_rd) rd_line[rd_lat - 4'h1] <= 1'b1;
			if (is_wr) wr_line[wr_lat - 4'h1] <= 1'b1;
		end
	end

	// access address and auto-precharge bookkeeping
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_bank_o <= '0;
			acc_row_o <= '0;
			acc_col_o <= '0;
			ap_pend <= 1'b0;
			ap_bank <= '0;
		end else if (is_rd || is_wr) begin
			acc_bank_o <= s_ba;
			acc_row_o <= row_of[s_ba];
			// bit ten sits above the column field, so it never reaches the column
			acc_col_o <= s_addr[`COL_W-1:0];
			ap_pend <= s_addr[`ADDR_AP_BIT];
			ap_bank <= s_ba;
		end else if (burst_end) begin
			ap_pend <= 1'b0;
		end
	end

	// burst engine: counts half burst cycles; a new start reloads for gapless flow
	// the preamble phase stays unused: the read line marks the preamble on its own
	ddr2_cmd_pkg::phase_type phase;
	logic [`CNT_W-1:0] left;
	logic writing;
	logic start;
	assign start = rd_line[0] | wr_line[0];
	assign burst_end = phase == ddr2_cmd_pkg::PH_DATA && left == `CNT_W'(1) && !start;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase <= ddr2_cmd_pkg::PH_IDLE;
			left <= '0;
			writing <= 1'b0;
		end else if (start) begin
			phase <= ddr2_cmd_pkg::PH_DATA;
			left <= half_bl;
			writing <= wr_line[0];
		end else begin
			unique case (phase)
				ddr2_cmd_pkg::PH_IDLE: phase <= ddr2_cmd_pkg::PH_IDLE;
				ddr2_cmd_pkg::PH_PRE: phase <= ddr2_cmd_pkg::PH_DATA;
				ddr2_cmd_pkg::PH_DATA: begin
					left <= left - `CNT_W'(1);
					if (left == `CNT_W'(1)) phase <= ddr2_cmd_pkg::PH_IDLE;
				end
				default: phase <= ddr2_cmd_pkg::PH_IDLE;
			endcase
		end
	end

	// read preamble one clock ahead of data, marked by the read delay line
	// the last stage is the cycle just before data, so the strobe enable has no gap
	logic rd_pre;
	assign rd_pre = rd_line[0] && !(phase == ddr2_cmd_pkg::PH_DATA && !writing);

	// read outputs: strobe low for preamble, toggles per element in the link clock
	logic rd_act;
	assign rd_act = phase == ddr2_cmd_pkg::PH_DATA && !writing;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dq_oe_o <= 1'b0;
			dqs_oe_o <= 1'b0;
			dq_o <= '0;
		end else begin
			dq_oe_o <= rd_act;
			dqs_oe_o <= rd_act || rd_pre;
			dq_o <= rd_act ? rd_data_i : '0;
		end
	end

	// strobe toggles on link clock; level crosses by two flops so only the second is read
	// limitation: a burst shorter than a link period may give no strobe edge at all
	logic act_l1, act_l2, dqs_q;
	always_ff @(posedge clk_link_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			act_l1 <= 1'b0;
			act_l2 <= 1'b0;
			dqs_q <= 1'b0;
		end else begin
			act_l1 <= dq_oe_o;
			act_l2 <= act_l1;
			dqs_q <= act_l2 ? !dqs_q : 1'b0; // low outside data
		end
	end
	assign dqs_o = dqs_q;

	// write capture in the link domain: each write start flips a toggle that
	// crosses by two flops, and a third flop finds the flip; a window only a few
	// command clocks wide would slip between edges of the slower link clock
	// limitation: two write starts inside one link period cancel each other
	logic wr_tog;
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) wr_tog <= 1'b0;
		else if (start && wr_line[0]) wr_tog <= !wr_tog;
	end
	logic tog_s1, tog_s2, tog_s3;
	logic [`CNT_W-1:0] wr_left;
	// burst length is a mode setting, steady while writes run, so it is read directly
	always_ff @(posedge clk_link_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
			wr_left <= '0;
			wr_en_o <= 1'b0;
			wr_data_o <= '0;
			wr_be_o <= '0;
		end else begin
			tog_s1 <= wr_tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			if (tog_s2 != tog_s3) wr_left <= half_bl;
			else if (wr_left != '0) wr_left <= wr_left - `CNT_W'(1);
			wr_en_o <= wr_left != '0; // data outside the burst ignored
			wr_data_o <= wr_left != '0 ? dq_i : '0;
			wr_be_o <= wr_left != '0 ? ~dm_i : '0;
		end
	end

	// checks on the command side
	mode_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_LOAD && s_ba == `MR_SEL_MODE |=> mode_o == $past(s_addr))
		else $error("mode register not loaded");
	deselect_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_cs_n |=> $stable(bank_open_o) || $past(burst_end))
		else $error("deselect changed bank state");
	nop_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!s_cs_n && s_ras_n && s_cas_n && s_we_n |=> $stable(mode_o))
		else $error("nop changed mode");
	act_open_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_ACT |=> bank_open_o[$past(s_ba)])
		else $error("activate did not open bank");
	pre_all_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_PRE && s_addr[`ADDR_AP_BIT] |=> bank_open_o == '0)
		else $error("precharge all left a bank open");
	read_lat_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		is_rd && rd_lat == 4'h5 && add_lat == 4'h0 |-> ##7 dq_oe_o)
		else $error("read data late");
	rd_release_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$fell(rd_act) |=> !dq_oe_o)
		else $error("bus not released after read");
	wr_lat_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		is_wr |-> wr_lat == rd_lat - 4'h1)
		else $error("write latency mismatch");
	preamble_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(dq_oe_o) |-> $past(dqs_oe_o))
		else $error("no read preamble");
	// further checks on state updates and the burst data path
	ext_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_LOAD && s_ba == `MR_SEL_EXT |=> ext_mode_o == $past(s_addr))
		else $error("extended mode not loaded");
	act_row_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_ACT |=> row_of[$past(s_ba)] == $past(s_addr))
		else $error("activate did not store row");
	pre_one_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_PRE && !s_addr[`ADDR_AP_BIT] |=> !bank_open_o[$past(s_ba)])
		else $error("precharge left bank open");
	ap_close_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		burst_end && ap_pend && cmd != ddr2_cmd_pkg::CMD_ACT |=> !bank_open_o[$past(ap_bank)])
		else $error("auto precharge left bank open");
	other_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		cmd == ddr2_cmd_pkg::CMD_OTHER |=> $stable(bank_open_o) || $past(burst_end))
		else $error("unhandled command changed banks");
	burst_load_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		start |=> left == $past(half_bl))
		else $error("burst length not loaded");
	gapless_rd_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_act && start && !wr_line[0] |=> rd_act)
		else $error("gap between read bursts");
	rd_data_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		rd_act |=> dq_o == $past(rd_data_i))
		else $error("read data not driven");
	strobe_cover_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		dq_oe_o |-> dqs_oe_o)
		else $error("read data without strobe");
	bus_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!dq_oe_o |-> dq_o == '0)
		else $error("data driven outside burst");
	col_take_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		is_rd || is_wr |=> acc_col_o == $past(s_addr[`COL_W-1:0]))
		else $error("start column not taken");
	ap_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		is_rd || is_wr |=> ap_pend == $past(s_addr[`ADDR_AP_BIT]))
		else $error("auto precharge flag not taken");
	wr_start_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		start && wr_line[0] |=> $changed(wr_tog))
		else $error("write start not signalled");

endmodule : ddr2_command_protocol

//--- verif/ddr2_ctrl_model.sv
// controller-side model: drives command pins and write data
`timescale 1ns/10ps
`include "ddr2_cmd_params.svh"
module ddr2_ctrl_model (
	input wire logic clk_sys_i, // command clock
	input wire logic clk_link_i, // strobe clock
	output logic cs_n_o, // chip select
	output logic ras_n_o, // row strobe
	output logic cas_n_o, // column strobe
	output logic we_n_o, // write enable
	output logic [`BANK_W-1:0] ba_o, // bank address
	output logic [`ROW_W-1:0] addr_o, // address
	output logic [`DQ_W-1:0] dq_o, // write data
	output logic [`DM_W-1:0] dm_o // write mask
);
	logic wr_active = 1'b0;
	logic [`DQ_W-1:0] wdata = 16'h0000;
	logic [`DM_W-1:0] wmask = 2'h0;
	// deselected at start so reset sees no command
	initial begin
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = 3'h0;
		addr_o = 13'h0000;
		dq_o = 16'h0000;
		dm_o = 2'h0;
	end
	// released data lines toggle so a stale value never looks valid
	always @(posedge clk_link_i) begin
		dq_o <= wr_active ? wdata : ~dq_o;
		dm_o <= wr_active ? wmask : ~dm_o;
	end
	// one command, then nop for the spacing the caller keeps
	task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [12:0] a,
		input int gap);
		@(posedge clk_sys_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= p;
		ba_o <= b;
		addr_o <= a;
		@(posedge clk_sys_i);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
		repeat (gap) @(posedge clk_sys_i);
	endtask : cmd
	// whole burst, data held across the strobe window, never cut short
	task automatic wr(input logic [2:0] b, input logic [12:0] a, input logic [15:0] d,
		input logic [1:0] m);
		wdata <= d;
		wmask <= m;
		wr_active <= 1'b1;
		repeat (2) @(posedge clk_link_i);
		cmd(4'h4, b, a, 0);
		repeat (10) @(posedge clk_link_i);
		wr_active <= 1'b0;
	endtask : wr
endmodule : ddr2_ctrl_model

//--- verif/tb_top.sv
// self-checking bench for the ddr2 command protocol block
`timescale 1ns/10ps
`include "ddr2_cmd_params.svh"
module tb_top;
	typedef struct {logic [2:0] ba; logic [12:0] v, md, ext; int dl, len;} row_type;
	row_type rows[6] = '{
		'{3'h0, 13'h0052, 13'h0052, 13'h0000, 2, 2},
		'{3'h1, 13'h0008, 13'h0052, 13'h0008, 3, 2},
		'{3'h2, 13'h1FFF, 13'h0052, 13'h0008, 3, 2},
		'{3'h1, 13'h0000, 13'h0052, 13'h0000, 2, 2},
		'{3'h0, 13'h003A, 13'h003A, 13'h0000, 0, 4},
		'{3'h0, 13'h0032, 13'h0032, 13'h0000, 0, 2}};
	logic clk_sys_i = 1'b0;
	logic clk_link_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cs_n, ras_n, cas_n, we_n, dq_oe, dqs, dqs_oe, wr_en;
	logic [2:0] ba, acc_bank;
	logic [12:0] addr, acc_row, mode, ext_mode;
	logic [15:0] dq, dq_o, wr_data;
	logic [15:0] rd_data = 16'hA5C3;
	logic [1:0] dm, wr_be;
	logic [9:0] acc_col;
	logic [7:0] bank_open;
	int fails = 0;
	int checked = 0;
	int lat, len, base, n;
	logic pre;
	always #2.5 clk_sys_i = ~clk_sys_i;
	always #40 clk_link_i = ~clk_link_i;
	ddr2_ctrl_model model (.clk_sys_i(clk_sys_i), .clk_link_i(clk_link_i), .cs_n_o(cs_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr),
		.dq_o(dq), .dm_o(dm));
	ddr2_command_protocol uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.clk_link_i(clk_link_i), .cke_i(1'b1), .cs_n_i(cs_n), .ras_n_i(ras_n),
		.cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dq_i(dq), .dm_i(dm),
		.rd_data_i(rd_data), .dq_o(dq_o), .dq_oe_o(dq_oe), .dqs_o(dqs), .dqs_oe_o(dqs_oe),
		.wr_en_o(wr_en), .wr_data_o(wr_data), .wr_be_o(wr_be), .acc_bank_o(acc_bank),
		.acc_row_o(acc_row), .acc_col_o(acc_col), .mode_o(mode), .ext_mode_o(ext_mode),
		.bank_open_o(bank_open));
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	// read, then time the data window in command clocks (sampled on falling edges)
	task automatic rd(input logic [2:0] b, input logic [12:0] a);
		model.cmd(4'h5, b, a, 0);
		lat = 0;
		len = 0;
		while (dq_oe !== 1'b1 && lat < 200) begin
			pre = dqs_oe;
			@(negedge clk_sys_i);
			lat++;
		end
		chk(16'(dq_oe), 16'h0001);
		chk(16'(pre), 16'h0001);
		while (dq_oe === 1'b1 && len < 20) begin
			chk(dq_o, rd_data);
			@(negedge clk_sys_i);
			len++;
		end
		repeat (24) @(posedge clk_sys_i);
		chk(16'({dq_oe, dqs_oe}), 16'h0000);
	endtask : rd
	// hang guard, far beyond the expected run
	initial begin
		#100000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_link_i);
		reset_n_i <= 1'b1;
		@(negedge clk_sys_i);
		chk(mode, `MR_RESET_MODE);
		chk(ext_mode, `MR_RESET_EXT);
		chk(16'({bank_open, dq_oe, wr_en}), 16'h0000);
		// latency reference with the reset mode
		model.cmd(4'h3, 3'h2, 13'h0ABC, 24);
		@(posedge clk_link_i);
		rd(3'h2, 13'h0407);
		base = lat;
		// mode loads of both registers and of an ignored select, each followed by an auto-precharge read
		foreach (rows[i]) begin
			model.cmd(4'h0, rows[i].ba, rows[i].v, 24);
			chk(mode, rows[i].md);
			chk(ext_mode, rows[i].ext);
			model.cmd(4'h3, 3'h2, 13'h0ABC, 24);
			chk(16'(bank_open), 16'h0004);
			@(posedge clk_link_i);
			rd(3'h2, 13'h0407);
			chk(16'(lat - base), 16'(rows[i].dl));
			chk(16'(len), 16'(rows[i].len));
			chk({acc_bank, acc_row}, {3'h2, 13'h0ABC});
			chk(16'(acc_col), 16'h0007);
			chk(16'(bank_open), 16'h0000);
		end
		// deselect carrying an activate pattern, then a nop: nothing opens
		model.cmd(4'hB, 3'h1, 13'h0123, 4);
		model.cmd(4'h7, 3'h1, 13'h0123, 24);
		chk(16'(bank_open), 16'h0000);
		model.cmd(4'h3, 3'h1, 13'h0111, 24);
		model.cmd(4'h3, 3'h6, 13'h0666, 24);
		chk(16'(bank_open), 16'h0042);
		// back-to-back reads half a burst apart, no auto precharge
		model.cmd(4'h5, 3'h1, 13'h0010, 0);
		rd(3'h1, 13'h0014);
		chk(16'(len), 16'h0004);
		chk(16'(bank_open), 16'h0042);
		model.cmd(4'h2, 3'h1, 13'h0000, 24);
		chk(16'(bank_open), 16'h0040);
		model.cmd(4'h2, 3'h0, 13'h0400, 24);
		chk(16'(bank_open), 16'h0000);
		// masked write; toggling data after the burst must be ignored
		model.cmd(4'h3, 3'h5, 13'h0055, 24);
		n = 0;
		fork
			model.wr(3'h5, 13'h0003, 16'h3C5A, 2'h1);
			repeat (24) begin
				@(negedge clk_link_i);
				if (wr_en === 1'b1) begin
					n++;
					chk(wr_data, 16'h3C5A);
					chk(16'(wr_be), 16'h0002);
				end
			end
		join
		chk(16'(n), 16'(`BL4_HALF));
		end_of_test();
	end
endmodule : tb_top
